// >>> design/asrp_buf.sv
`timescale 1ns/1ps
// ======================================================
// two entry valid/ready buffer
module asrp_buf (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic in_valid, // source has a word
    output logic in_ready, // buffer can take a word
    input wire asrp_pkg::asrp_word_type in_word, // incoming word
    output logic out_valid, // word available
    input wire logic out_ready, // drain takes word
    output asrp_pkg::asrp_word_type out_word // head word
);
    asrp_pkg::asrp_word_type mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_word = mem[rd_ptr];

    // pointers and occupancy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage holds no reset; count guards validity
    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr] <= in_word;
    end
endmodule : asrp_buf

// >>> design/asrp_port.sv
`timescale 1ns/1ps
// Operation
// - parallel mode: pins carry bits 7 to 10
// - external clock: chain pin is data input
// - chain level appears after sixteen clocks
// - internal clock, read-mode high: send during conversion
// - internal clock, read-mode low: send after conversion
// - shift register sends msb first
// - coding select chooses output coding
// - internal clock: data changes as the clock returns to idle, stable on the other edge
// - external, no invert: change on rising
// - external, invert: change on falling
// - clock pin driven only with internal clock or in parallel mode
// - frame marker frames internal clock transfers
// - polarity low: frame marker high while valid
// - polarity high: frame marker low while valid
// - clock source selects internal or host clock
// - high straight binary, low msb inverted
// - outputs enabled only with select and read low
// - busy high from start until latched
module asrp_port (
    input wire logic clk, // system clock, 25 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic conv_start, // conversion start pulse, same domain
    input wire logic conv_done, // conversion result ready pulse
    input wire logic [15:0] conv_result, // raw conversion result
    input wire asrp_pkg::asrp_cfg_type cfg, // configuration pins
    input wire logic chip_select_n, // chip select pin, active low
    input wire logic read_strobe_n, // read strobe pin, active low
    input wire logic read_mode_or_chain_input, // shared pin input
    input wire logic sclk_in, // clock pin input
    output logic read_mode_or_chain_out, // shared pin output
    output logic read_mode_or_chain_oe, // shared pin enable
    output logic serial_result_out, // data pin output
    output logic serial_result_oe, // data pin enable
    output logic sclk_out, // clock pin output
    output logic sclk_oe, // clock pin enable
    output logic frame_marker_out, // frame pin output
    output logic frame_marker_oe, // frame pin enable
    output logic busy, // conversion busy
    output logic buf_ready // buffer can take a result
);
    // ======================================================
    // pin synchronisers
    logic cs_n_s;
    logic rd_n_s;
    logic chain_s;
    logic sclk_s;

    asrp_sync u_sync_cs (.clk(clk), .sys_rst(sys_rst), .async_in(chip_select_n),
        .sync_out(cs_n_s));
    asrp_sync u_sync_rd (.clk(clk), .sys_rst(sys_rst), .async_in(read_strobe_n),
        .sync_out(rd_n_s));
    asrp_sync u_sync_ch (.clk(clk), .sys_rst(sys_rst), .async_in(read_mode_or_chain_input),
        .sync_out(chain_s));
    asrp_sync u_sync_ck (.clk(clk), .sys_rst(sys_rst), .async_in(sclk_in),
        .sync_out(sclk_s));

    // ======================================================
    // mode decode
    wire serial_mode = cfg.serial_parallel_select;
    wire ext_clk = cfg.clock_source_select;
    wire bus_enable = !cs_n_s && !rd_n_s;
    wire read_during = !ext_clk && chain_s;
    wire frame_active_lvl = !cfg.frame_marker_polarity;

    // ======================================================
    // coding and result buffer
    asrp_pkg::asrp_word_type coded;
    asrp_pkg::asrp_word_type head;
    logic head_valid;
    logic head_take;

    assign coded.value = {conv_result[15] ^ ~cfg.output_coding_select, conv_result[14:0]};

    asrp_buf u_buf (.clk(clk), .sys_rst(sys_rst), .in_valid(conv_done),
        .in_ready(buf_ready), .in_word(coded), .out_valid(head_valid),
        .out_ready(head_take), .out_word(head));

    // ======================================================
    // busy flag
    logic converting;

    // set wins over the done pulse in the same cycle
    wire next_converting = conv_start || (converting && !conv_done);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            converting <= 1'b0;
        end else if (conv_start) begin
            converting <= 1'b1;
        end else if (conv_done) begin
            converting <= 1'b0;
        end
    end

    // ======================================================
    // external clock edge detection
    logic sclk_d;
    wire ext_rise = sclk_s && !sclk_d;
    wire ext_fall = !sclk_s && sclk_d;
    // update edge selected by the invert pin
    wire ext_update = cfg.shift_clock_invert ? ext_fall : ext_rise;

    always_ff @(posedge clk) begin
        if (sys_rst) sclk_d <= 1'b0;
        else sclk_d <= sclk_s;
    end

    // ======================================================
    // internal shift clock generator
    logic [3:0] div_cnt;
    logic int_clk;
    wire div_wrap = (div_cnt == asrp_pkg::sclk_half_cycles - 4'h1);
    // data changes only at the active-to-inactive point, so it is steady on the inactive-to-active edge
    wire int_update = div_wrap && int_clk;

    // ======================================================
    // shifter state
    asrp_pkg::asrp_state_type state;
    asrp_pkg::asrp_state_type next_state;
    logic [15:0] shreg;
    logic [4:0] bit_cnt;
    logic [15:0] next_shreg;
    logic [4:0] next_bit_cnt;

    wire shift_tick = ext_clk ? ext_update : int_update;
    // after-conversion read waits for busy to fall
    wire may_start = read_during || !converting || ext_clk;
    wire start = (state == asrp_pkg::asrp_idle) && serial_mode && bus_enable
        && head_valid && may_start;
    wire last_bit = (bit_cnt == asrp_pkg::frame_bits - 5'h1);
    // chain level enters the tail, surfacing after sixteen clocks
    wire chain_bit = ext_clk ? chain_s : 1'b0;

    assign head_take = start;

    // next state and shift register
    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        case (state)
            asrp_pkg::asrp_idle: begin
                if (start) begin
                    next_state = asrp_pkg::asrp_shift;
                    next_shreg = head.value;
                    next_bit_cnt = 5'h00;
                end
            end
            asrp_pkg::asrp_shift: begin
                if (!bus_enable) begin
                    next_state = asrp_pkg::asrp_idle;
                end else if (shift_tick) begin
                    next_shreg = {shreg[14:0], chain_bit};
                    next_bit_cnt = bit_cnt + 5'h01;
                    if (last_bit && !ext_clk) next_state = asrp_pkg::asrp_done;
                end
            end
            asrp_pkg::asrp_done: begin
                if (!bus_enable) next_state = asrp_pkg::asrp_idle;
            end
            default: next_state = asrp_pkg::asrp_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= asrp_pkg::asrp_idle;
            shreg <= asrp_pkg::result_reset;
            bit_cnt <= 5'h00;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
        end
    end

    // internal clock runs only during a frame so idle clock stays low
    always_ff @(posedge clk) begin
        if (sys_rst || state != asrp_pkg::asrp_shift || ext_clk) begin
            div_cnt <= 4'h0;
            int_clk <= 1'b0;
        end else if (div_wrap) begin
            div_cnt <= 4'h0;
            int_clk <= ~int_clk;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // ======================================================
    // pin multiplexing
    wire framing = (state == asrp_pkg::asrp_shift);
    wire sclk_level = int_clk ^ cfg.shift_clock_invert;
    wire [15:0] par = head_valid ? head.value : asrp_pkg::result_reset;

    wire next_chain_out = par[asrp_pkg::pos_chain_pin];
    wire next_chain_oe = !serial_mode && bus_enable;
    wire next_data_out = serial_mode ? shreg[15] : par[asrp_pkg::pos_data_pin];
    wire next_data_oe = bus_enable;
    wire next_clk_out = serial_mode ? sclk_level : par[asrp_pkg::pos_clock_pin];
    // clock pin driven only for internal clock or parallel bit
    wire next_clk_oe = bus_enable && !(serial_mode && ext_clk);
    wire next_frame_out = serial_mode ? (framing ? frame_active_lvl : ~frame_active_lvl)
        : par[asrp_pkg::pos_frame_pin];
    wire next_frame_oe = bus_enable && !(serial_mode && ext_clk);

    // registered pin drivers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            read_mode_or_chain_out <= 1'b0;
            read_mode_or_chain_oe <= 1'b0;
            serial_result_out <= 1'b0;
            serial_result_oe <= 1'b0;
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            frame_marker_out <= 1'b0;
            frame_marker_oe <= 1'b0;
            busy <= 1'b0;
        end else begin
            read_mode_or_chain_out <= next_chain_out;
            read_mode_or_chain_oe <= next_chain_oe;
            serial_result_out <= next_data_out;
            serial_result_oe <= next_data_oe;
            sclk_out <= next_clk_out;
            sclk_oe <= next_clk_oe;
            frame_marker_out <= next_frame_out;
            frame_marker_oe <= next_frame_oe;
            busy <= next_converting;
        end
    end
endmodule : asrp_port

// >>> design/asrp_sync.sv
`timescale 1ns/1ps
// ======================================================
// two flop synchroniser for pin inputs
module asrp_sync (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic async_in, // pin level
    output logic sync_out // synchronised level
);
    logic stage1;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : asrp_sync

// >>> dv/asrp_host_model.sv
`timescale 1ns/1ps
// ========
// host reading results; clocks frames itself when the host clock is selected
module asrp_host_model (
    input wire logic clk, // system clock
    input wire logic go, // hold a read open
    input wire asrp_pkg::asrp_cfg_type cfg, // pin setup
    input wire logic sclk_pin, // clock pin level
    input wire logic data_pin, // data pin level
    input wire logic frame_pin, // marker pin level
    output logic cs_n, // select
    output logic rd_n, // read
    output logic sclk_drv, // host clock
    output logic [31:0] word, // captured bits
    output logic [7:0] nbits // bit count
);
    logic sclk_q;
    logic take;
    assign cs_n = !go;
    assign rd_n = !go;
    // 320 ns clock only inside a read, idle at the invert level between frames
    initial begin
        forever begin
            @(negedge clk);
            sclk_drv = cfg.shift_clock_invert;
            if (go && cfg.clock_source_select) begin
                #333;
                repeat (32) begin
                    #160 sclk_drv = !cfg.shift_clock_invert;
                    #160 sclk_drv = cfg.shift_clock_invert;
                end
                wait (!go);
            end
        end
    end
    // bit taken just before the updating edge lands, or at the device clock's mid-bit edge
    assign take = cfg.clock_source_select ? (sclk_q == cfg.shift_clock_invert && sclk_pin != sclk_q)
        : (frame_pin != cfg.frame_marker_polarity && sclk_pin != sclk_q
        && sclk_pin != cfg.shift_clock_invert);
    always @(posedge clk) begin
        sclk_q <= sclk_pin;
        if (!go) begin
            word <= 32'h0;
            nbits <= 8'h00;
        end else if (take) begin
            word <= {word[30:0], data_pin};
            nbits <= nbits + 8'h01;
        end
    end
endmodule : asrp_host_model

// >>> dv/asrp_port_checker.sv
`timescale 1ns/1ps
// ========
// pin gating, frame and busy checks on the result port
module asrp_port_checker (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic conv_start, // start pulse
    input wire logic conv_done, // done pulse
    input wire asrp_pkg::asrp_cfg_type cfg, // pin setup
    input wire logic chip_select_n, // select
    input wire logic read_strobe_n, // read
    input wire logic read_mode_or_chain_oe, // chain pin oe
    input wire logic serial_result_out, // data
    input wire logic serial_result_oe, // data oe
    input wire logic sclk_out, // clock
    input wire logic sclk_oe, // clock oe
    input wire logic frame_marker_out, // marker
    input wire logic frame_marker_oe, // marker oe
    input wire logic busy, // busy
    input wire logic buf_ready // buffer room
);
    logic fm_act;
    logic [7:0] gap;
    logic [7:0] flen;
    // active marker level is the inverse of the polarity pin
    assign fm_act = frame_marker_oe && (frame_marker_out != cfg.frame_marker_polarity);
    // saturating counts: cycles since the read was released, cycles of marker
    always_ff @(posedge clk) begin
        gap <= (sys_rst || !(chip_select_n || read_strobe_n)) ? 8'h00 : gap + 8'(gap != 8'hff);
        flen <= (sys_rst || !fm_act) ? 8'h00 : flen + 8'(flen != 8'hff);
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence frame_open;
        $rose(fm_act);
    endsequence
    sequence frame_held;
        fm_act [*8];
    endsequence
    chk_out_gated:
    assert property (gap > 8'h06 |-> !(serial_result_oe || sclk_oe || frame_marker_oe
        || read_mode_or_chain_oe)) else $error("pin driven with read released");
    chk_chain_input:
    assert property (cfg.serial_parallel_select && $past(cfg.serial_parallel_select)
        |-> !read_mode_or_chain_oe) else $error("chain pin driven in serial mode");
    chk_ext_nodrive:
    assert property (cfg.serial_parallel_select && cfg.clock_source_select && cfg == $past(cfg)
        |-> !sclk_oe && !frame_marker_oe) else $error("clock or marker driven, host clock");
    chk_busy_set:
    assert property (conv_start |=> busy) else $error("busy not raised");
    chk_busy_hold:
    assert property (busy && !conv_done |=> busy) else $error("busy dropped early");
    chk_busy_clear:
    assert property (conv_done && buf_ready && !conv_start |=> !busy) else $error("busy stuck");
    chk_frame_hold:
    assert property (frame_open |-> frame_held) else $error("marker pulse too short");
    chk_frame_len:
    assert property ($fell(fm_act) && gap == 8'h00 |-> flen >= 8'h3c && flen <= 8'hc0)
        else $error("frame length wrong");
    chk_data_fall:
    assert property (fm_act && $changed(sclk_out) && sclk_out != cfg.shift_clock_invert
        |-> $stable(serial_result_out)) else $error("data moved on mid-bit clock edge");
    chk_half_clk:
    assert property (fm_act && $changed(sclk_out) |=> $stable(sclk_out))
        else $error("shift clock too fast");
endmodule : asrp_port_checker
bind asrp_port asrp_port_checker u_chk (
    .clk(clk), .sys_rst(sys_rst), .conv_start(conv_start), .conv_done(conv_done), .cfg(cfg),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .read_mode_or_chain_oe(read_mode_or_chain_oe), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .frame_marker_out(frame_marker_out), .frame_marker_oe(frame_marker_oe), .busy(busy),
    .buf_ready(buf_ready)
);

// >>> dv/asrp_port_tb.sv
`timescale 1ns/1ps
// ========
// bench for the serial result port
module asrp_port_tb;
    logic clk, sys_rst, conv_start, conv_done, chain, go, cs_n, rd_n, sclk_drv, sd_last;
    logic rmc_out, rmc_oe, sd_out, sd_oe, sclk_out, sclk_oe, fm_out, fm_oe, busy, buf_ready;
    logic [15:0] conv_result, r1, r2;
    logic [31:0] word;
    logic [7:0] nbits;
    asrp_pkg::asrp_cfg_type cfg;
    integer seed, n_fail, num_checks, cyc;
    // released data and marker lines show the inverse of their last level
    always @(posedge clk) if (sd_oe) sd_last <= sd_out;
    asrp_port u_dut (
        .clk(clk), .sys_rst(sys_rst), .conv_start(conv_start), .conv_done(conv_done),
        .conv_result(conv_result), .cfg(cfg), .chip_select_n(cs_n), .read_strobe_n(rd_n),
        .read_mode_or_chain_input(rmc_oe ? rmc_out : chain),
        .sclk_in(sclk_oe ? sclk_out : sclk_drv), .read_mode_or_chain_out(rmc_out),
        .read_mode_or_chain_oe(rmc_oe), .serial_result_out(sd_out), .serial_result_oe(sd_oe),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .frame_marker_out(fm_out),
        .frame_marker_oe(fm_oe), .busy(busy), .buf_ready(buf_ready)
    );
    asrp_host_model u_host (
        .clk(clk), .go(go), .cfg(cfg), .sclk_pin(sclk_oe ? sclk_out : sclk_drv),
        .data_pin(sd_oe ? sd_out : !sd_last), .frame_pin(fm_oe ? fm_out : !fm_out),
        .cs_n(cs_n), .rd_n(rd_n), .sclk_drv(sclk_drv), .word(word), .nbits(nbits)
    );
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    function automatic logic [15:0] coded(input logic [15:0] r);
        coded = cfg.output_coding_select ? r : {!r[15], r[14:0]};
    endfunction : coded
    // one cycle pulse on start and/or done
    task automatic conv(input logic s, input logic d, input logic [15:0] v);
        @(negedge clk);
        conv_start = s;
        conv_done = d;
        conv_result = v;
        @(negedge clk);
        conv_start = 1'b0;
        conv_done = 1'b0;
        repeat (4) @(negedge clk);
    endtask : conv
    // one read; the host holds select until the frame has had time to end
    task automatic rd(input logic [31:0] exp, input logic [7:0] n);
        @(negedge clk);
        go = 1'b1;
        repeat (40) @(negedge clk);
        for (int i = 0; i < 600 && nbits !== n; i++) @(negedge clk);
        repeat (20) @(negedge clk);
        check("bits", {24'h0, nbits}, {24'h0, n});
        check("word", word, exp);
        if (!cfg.clock_source_select) check("marker", {31'h0, fm_out}, {31'h0, cfg[2]});
        go = 1'b0;
        repeat (8) @(negedge clk);
    endtask : rd
    initial begin
        clk = 1'b0;
        forever #20 clk = !clk;
    end
    // run limit well past the longest expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end
    initial begin
        seed = 32'hf8daaaf2;
        n_fail = 0;
        num_checks = 0;
        cyc = 0;
        sys_rst = 1'b1;
        {conv_start, conv_done, chain, go, conv_result} = 20'h0;
        cfg = 5'h11;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        // internal clock, every marker polarity and coding
        for (int k = 0; k < 4; k++) begin
            {cfg.output_coding_select, cfg.frame_marker_polarity} = 2'(k);
            r1 = (k == 0) ? 16'h8000 : 16'($random(seed));
            conv(1'b1, 1'b0, r1);
            conv(1'b0, 1'b1, r1);
            rd({16'h0, coded(r1)}, 8'h10);
        end
        // read with a conversion running: held back, or sent at once
        for (int k = 0; k < 2; k++) begin
            chain = k[0];
            r1 = 16'($random(seed));
            r2 = 16'($random(seed));
            conv(1'b1, 1'b0, r1);
            conv(1'b0, 1'b1, r1);
            conv(1'b1, 1'b0, r1);
            rd(k[0] ? {16'h0, coded(r1)} : 32'h0, k[0] ? 8'h10 : 8'h00);
            check("busy", {31'h0, busy}, 32'h1);
            conv(1'b0, 1'b1, r2);
            if (!k[0]) rd({16'h0, coded(r1)}, 8'h10);
            rd({16'h0, coded(r2)}, 8'h10);
        end
        // host clock with a chained level behind the result
        cfg.clock_source_select = 1'b1;
        for (int k = 0; k < 2; k++) begin
            cfg.shift_clock_invert = k[0];
            chain = !k[0];
            r1 = 16'($random(seed));
            conv(1'b1, 1'b0, r1);
            conv(1'b0, 1'b1, r1);
            rd({coded(r1), {16{chain}}}, 8'h20);
        end
        // two results fill the buffer while the host stalls, a third is lost
        cfg.clock_source_select = 1'b0;
        chain = 1'b0;
        r1 = 16'($random(seed));
        r2 = ~r1;
        conv(1'b0, 1'b1, r1);
        conv(1'b0, 1'b1, r2);
        check("ready", {31'h0, buf_ready}, 32'h0);
        conv(1'b0, 1'b1, 16'h1234);
        rd({16'h0, coded(r1)}, 8'h10);
        rd({16'h0, coded(r2)}, 8'h10);
        rd(32'h0, 8'h00);
        // parallel mode: shared pins carry bits 7 to 10
        conv(1'b0, 1'b1, 16'h0280);
        cfg.serial_parallel_select = 1'b0;
        go = 1'b1;
        repeat (10) @(negedge clk);
        check("par", {28'h0, fm_out, sclk_out, sd_out, rmc_out}, 32'h5);
        check("par_oe", {28'h0, fm_oe, sclk_oe, sd_oe, rmc_oe}, 32'hf);
        end_sim();
    end
endmodule : asrp_port_tb

// >>> inc/asrp_pkg.sv
package asrp_pkg;
    // ======================================================
    // widths and counts
    localparam int result_width = 16;
    localparam int bit_count_width = 5;
    localparam logic [4:0] frame_bits = 5'h10; // sixteen bits per frame
    // internal shift clock half period in system clocks
    localparam int sclk_half_ns = 80;
    localparam int clk_period_ns = 40;
    localparam logic [3:0] sclk_half_cycles = 4'((sclk_half_ns + clk_period_ns - 1) / clk_period_ns);
    // parallel bit positions carried by shared pins
    localparam int pos_chain_pin = 7;
    localparam int pos_data_pin = 8;
    localparam int pos_clock_pin = 9;
    localparam int pos_frame_pin = 10;
    localparam logic [15:0] result_reset = 16'h0000;

    typedef enum logic [1:0] {
        asrp_idle,
        asrp_shift,
        asrp_done
    } asrp_state_type;

    // one buffered conversion result
    typedef struct packed {
        logic [15:0] value;
    } asrp_word_type;

    // static serial configuration pins
    typedef struct packed {
        logic serial_parallel_select;
        logic clock_source_select;
        logic frame_marker_polarity;
        logic shift_clock_invert;
        logic output_coding_select;
    } asrp_cfg_type;
endpackage : asrp_pkg
